//--- core/acl_entry_staging_registers.sv
// Per-port access-control entry staging registers with an indirect table engine.
// Assumes an APB master on SYS_CLK; ports 1 to 7 each own a 16-entry table.
//
// Summary of operation
// - A 48-bit MAC compare value sits in bytes 0x602 (high) to 0x607 (low).
// - A 16-bit EtherType sits in bytes 0x608 (high) and 0x609 (low).
// - Byte 0x60A holds priority mode in bits 7:6, priority in 5:3.
// - Bit 2 of byte 0x60A enables priority remarking for the entry.
// - Remark priority bits 2:1 sit in 0x60A bits 1:0, bit 0 in 0x60B bit 7.
// - Byte 0x60B holds map mode in bits 6:5; bits 4:0 reserved.
// - Byte 0x60D bits 6:0 form the forward map, bit 0 meaning port 1.
// - A forward map one permits forwarding to that port; zero excludes it.
// - A 16-bit ruleset sits in bytes 0x60E (high) and 0x60F (low).
// - Writing the low byte-select register starts a table transfer when the engine is idle.
// - High byte-select bit 0 picks 0x607, up to bit 7 picking 0x600.
// - Low byte-select bit 0 picks 0x60F, up to bit 7 picking 0x608.
// - Unselected staged bytes and table bytes stay untouched by a transfer.
// - Control register 0x612 holds direction (one is write) and entry index.
// - Control bit 6 reads zero during a table write, one once complete.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module acl_entry_staging_registers #(
    parameter int XFER_CYCLES = acl_stage_pkg::XFER_CYCLES
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [acl_stage_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    localparam int DONE_GAP = XFER_CYCLES + 1;
    // Last busy cycle counted from the first cycle after a start.
    localparam int XFER_LAST = XFER_CYCLES - 1;

    generate
        if (XFER_CYCLES < 1 || XFER_CYCLES > 255)
        begin : g_bad_cycles
            $error("XFER_CYCLES must lie between 1 and 255");
        end
    endgenerate

    logic [7:0] stage_reg [acl_stage_pkg::PORT_FIRST:acl_stage_pkg::PORT_LAST][0:15];
    logic [7:0] table_mem [acl_stage_pkg::PORT_FIRST:acl_stage_pkg::PORT_LAST][0:15][0:15];
    logic [7:0] sel_hi_reg [acl_stage_pkg::PORT_FIRST:acl_stage_pkg::PORT_LAST];
    logic [7:0] sel_lo_reg [acl_stage_pkg::PORT_FIRST:acl_stage_pkg::PORT_LAST];
    logic [4:0] ctrl_reg [acl_stage_pkg::PORT_FIRST:acl_stage_pkg::PORT_LAST];
    logic wr_done_reg [acl_stage_pkg::PORT_FIRST:acl_stage_pkg::PORT_LAST];
    logic rd_done_reg [acl_stage_pkg::PORT_FIRST:acl_stage_pkg::PORT_LAST];

    acl_stage_pkg::engine_state_t state_reg;
    logic [7:0] count_reg;
    logic [2:0] eng_port_reg;
    logic eng_dir_reg;
    logic [3:0] eng_index_reg;
    logic [15:0] eng_sel_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;

    logic [14:0] word_idx;
    logic [2:0] port_sel;
    logic [11:0] off;
    logic hit;
    logic setup;
    logic wr_en;
    logic start;
    logic done;
    logic [7:0] rd_byte;
    logic [7:0] wr_byte;

    function automatic logic [7:0] wmask(input logic [11:0] o);
        case (o)
            acl_stage_pkg::OFF_FIRST_RULE: wmask = acl_stage_pkg::FIRST_RULE_WMASK;
            acl_stage_pkg::OFF_CTRL: wmask = acl_stage_pkg::CTRL_WMASK;
            default: wmask = 8'hff;
        endcase
    endfunction

    assign word_idx = PADDR[acl_stage_pkg::ADDR_W-1:2];
    assign port_sel = word_idx[14:12];
    assign off = word_idx[11:0];
    // Misaligned offsets, port zero and offsets past the control register are refused.
    // A refused write is dropped and a refused read returns zero with an error.
    assign hit = (PADDR[1:0] == 2'h0) && (port_sel != 3'h0)
        && (off >= acl_stage_pkg::OFF_FIRST_RULE) && (off <= acl_stage_pkg::OFF_CTRL);
    assign setup = PSEL && !PENABLE;
    assign wr_en = PSEL && PENABLE && PWRITE && hit;
    assign start = wr_en && (off == acl_stage_pkg::OFF_SEL_LO) && (state_reg == acl_stage_pkg::ENG_IDLE);
    assign done = (state_reg == acl_stage_pkg::ENG_BUSY) && (count_reg == 8'h01);
    assign wr_byte = PWDATA[7:0] & wmask(off);
    assign PREADY = PSEL && PENABLE;
    assign PRDATA = prdata_reg;
    assign PSLVERR = pslverr_reg;

    // Field layout within a staged entry is plain byte storage; the match logic elsewhere
    // reads priority, remark, map mode, forward map and ruleset from these bytes.
    always_comb
    begin
        rd_byte = 8'h00;
        if (hit)
        begin
            if (off <= acl_stage_pkg::OFF_RULESET_LO)
                rd_byte = stage_reg[port_sel][off[3:0]];
            else if (off == acl_stage_pkg::OFF_SEL_HI)
                rd_byte = sel_hi_reg[port_sel];
            else if (off == acl_stage_pkg::OFF_SEL_LO)
                rd_byte = sel_lo_reg[port_sel];
            else
                rd_byte = {1'b0, wr_done_reg[port_sel], rd_done_reg[port_sel],
                    ctrl_reg[port_sel]};
        end
    end

    // Read data is captured in the setup cycle so the access phase needs no wait state.
    // The trade-off is that read data shows the register as it stood in the setup cycle.
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else if (setup)
        begin
            prdata_reg <= {24'h00_0000, rd_byte};
            pslverr_reg <= !hit;
        end
    end

    // Staged bytes: software writes, and selected bytes reload from the table on a read.
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            for (int p = acl_stage_pkg::PORT_FIRST; p <= acl_stage_pkg::PORT_LAST; p++)
            begin
                for (int k = 0; k < acl_stage_pkg::STAGE_BYTES; k++)
                begin
                    stage_reg[p][k] <= acl_stage_pkg::STAGE_RST;
                end
            end
        end
        else
        begin
            if (wr_en && off <= acl_stage_pkg::OFF_RULESET_LO)
                stage_reg[port_sel][off[3:0]] <= wr_byte;
            // The engine load comes last so a completing read wins over a racing write.
            if (done && !eng_dir_reg)
            begin
                for (int k = 0; k < acl_stage_pkg::STAGE_BYTES; k++)
                begin
                    if (eng_sel_reg[15 - k])
                        stage_reg[eng_port_reg][k] <= table_mem[eng_port_reg][eng_index_reg][k];
                end
            end
        end
    end

    // Table storage: only the selected bytes of the addressed entry change on a write.
    // Resetting the whole table costs area, but keeps reads of unwritten entries defined.
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            for (int p = acl_stage_pkg::PORT_FIRST; p <= acl_stage_pkg::PORT_LAST; p++)
            begin
                for (int e = 0; e < acl_stage_pkg::ENTRIES; e++)
                begin
                    for (int k = 0; k < acl_stage_pkg::STAGE_BYTES; k++)
                    begin
                        table_mem[p][e][k] <= 8'h00;
                    end
                end
            end
        end
        else if (done && eng_dir_reg)
        begin
            for (int k = 0; k < acl_stage_pkg::STAGE_BYTES; k++)
            begin
                if (eng_sel_reg[15 - k])
                    table_mem[eng_port_reg][eng_index_reg][k] <= stage_reg[eng_port_reg][k];
            end
        end
    end

    // Byte selects and control fields.
    // The status bits of the control register are not stored here and cannot be written.
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            for (int p = acl_stage_pkg::PORT_FIRST; p <= acl_stage_pkg::PORT_LAST; p++)
            begin
                sel_hi_reg[p] <= acl_stage_pkg::SEL_RST;
                sel_lo_reg[p] <= acl_stage_pkg::SEL_RST;
                ctrl_reg[p] <= acl_stage_pkg::CTRL_RST;
            end
        end
        else if (wr_en)
        begin
            if (off == acl_stage_pkg::OFF_SEL_HI)
                sel_hi_reg[port_sel] <= wr_byte;
            if (off == acl_stage_pkg::OFF_SEL_LO)
                sel_lo_reg[port_sel] <= wr_byte;
            if (off == acl_stage_pkg::OFF_CTRL)
                ctrl_reg[port_sel] <= wr_byte[4:0];
        end
    end

    // Completion flags: cleared when a transfer of that direction starts, set at its end.
    // A start needs an idle engine and a completion a busy one, so the two never meet.
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            for (int p = acl_stage_pkg::PORT_FIRST; p <= acl_stage_pkg::PORT_LAST; p++)
            begin
                wr_done_reg[p] <= acl_stage_pkg::DONE_RST;
                rd_done_reg[p] <= acl_stage_pkg::DONE_RST;
            end
        end
        else if (start)
        begin
            if (ctrl_reg[port_sel][acl_stage_pkg::CTRL_DIR_BIT])
                wr_done_reg[port_sel] <= 1'b0;
            else
                rd_done_reg[port_sel] <= 1'b0;
        end
        else if (done)
        begin
            if (eng_dir_reg)
                wr_done_reg[eng_port_reg] <= 1'b1;
            else
                rd_done_reg[eng_port_reg] <= 1'b1;
        end
    end

    // One engine serves all ports; a start while busy is ignored, so software must
    // wait for the completion flag before launching the next transfer.
    // A refused start still stores the new low select value; a launch takes its low select from its own write data.
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            state_reg <= acl_stage_pkg::ENG_IDLE;
            count_reg <= 8'h00;
            eng_port_reg <= 3'h1;
            eng_dir_reg <= 1'b0;
            eng_index_reg <= 4'h0;
            eng_sel_reg <= 16'h0000;
        end
        else
        begin
            case (state_reg)
                acl_stage_pkg::ENG_IDLE:
                begin
                    if (start)
                    begin
                        state_reg <= acl_stage_pkg::ENG_BUSY;
                        count_reg <= 8'(XFER_CYCLES);
                        eng_port_reg <= port_sel;
                        eng_dir_reg <= ctrl_reg[port_sel][acl_stage_pkg::CTRL_DIR_BIT];
                        eng_index_reg <= ctrl_reg[port_sel][3:0];
                        eng_sel_reg <= {sel_hi_reg[port_sel], wr_byte};
                    end
                end
                acl_stage_pkg::ENG_BUSY:
                begin
                    count_reg <= count_reg - 8'h01;
                    if (done)
                        state_reg <= acl_stage_pkg::ENG_IDLE;
                end
                default:
                begin
                    state_reg <= acl_stage_pkg::ENG_IDLE;
                end
            endcase
        end
    end

    // Probes for checking the first and the last byte position, each when selected and when unselected.
    logic [7:0] probe_first;
    logic [7:0] probe_last;
    logic [7:0] probe_tab_first;
    logic [7:0] probe_tab_last;
    logic probe_wr_done;
    logic probe_rd_done;
    assign probe_first = stage_reg[eng_port_reg][0];
    assign probe_last = stage_reg[eng_port_reg][15];
    assign probe_tab_first = table_mem[eng_port_reg][eng_index_reg][0];
    assign probe_tab_last = table_mem[eng_port_reg][eng_index_reg][15];
    assign probe_wr_done = wr_done_reg[eng_port_reg];
    assign probe_rd_done = rd_done_reg[eng_port_reg];

    // Assertions watch the engine port through the probes, as only one transfer runs at once.
    // A write to bytes 0x602 to 0x60F followed, after one idle bus cycle, by a read of the same byte must read back.
    stage_readback_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (wr_en && off >= acl_stage_pkg::OFF_MAC5 && off <= acl_stage_pkg::OFF_RULESET_LO
            && state_reg == acl_stage_pkg::ENG_IDLE)
        ##2 (setup && !PWRITE && PADDR == $past(PADDR, 2))
        |=> (PRDATA == {24'h00_0000, $past(PWDATA[7:0], 3)}))
        else $error("staged byte does not read back as written");

    start_busy_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        start |=> (state_reg == acl_stage_pkg::ENG_BUSY) && (eng_port_reg == $past(port_sel)))
        else $error("write to low byte select did not start a transfer");

    xfer_len_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        start |-> ##XFER_CYCLES done ##1 (state_reg == acl_stage_pkg::ENG_IDLE))
        else $error("transfer did not finish after the set cycle count");

    wr_status_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (start && ctrl_reg[port_sel][acl_stage_pkg::CTRL_DIR_BIT])
        |=> (!probe_wr_done throughout (##XFER_LAST 1'b1)) ##1 probe_wr_done)
        else $error("write status bit wrong during or after a table write");

    rd_status_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (start && !ctrl_reg[port_sel][acl_stage_pkg::CTRL_DIR_BIT])
        |=> (!probe_rd_done throughout (##XFER_LAST 1'b1)) ##1 probe_rd_done)
        else $error("read status bit wrong during or after a table read");

    busy_ignore_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (wr_en && off == acl_stage_pkg::OFF_SEL_LO && state_reg == acl_stage_pkg::ENG_BUSY)
        |=> (eng_port_reg == $past(eng_port_reg) && eng_sel_reg == $past(eng_sel_reg)))
        else $error("a start while busy disturbed the running transfer");

    index_latch_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        start |=> (eng_index_reg == $past(ctrl_reg[port_sel][3:0])
            && eng_dir_reg == $past(ctrl_reg[port_sel][acl_stage_pkg::CTRL_DIR_BIT])))
        else $error("transfer did not take direction and index from the control register");

    rd_load_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (done && !eng_dir_reg && eng_sel_reg[15]) |=> (probe_first == $past(probe_tab_first)))
        else $error("selected byte not loaded from the table on a read");

    unsel_keep_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (done && !eng_dir_reg && !eng_sel_reg[15] && !wr_en)
        |=> (probe_first == $past(probe_first)))
        else $error("unselected staged byte changed on a read");

    wr_store_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (done && eng_dir_reg && eng_sel_reg[0]) |=> (probe_tab_last == $past(probe_last)))
        else $error("selected byte not stored into the table on a write");

    wr_keep_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (done && eng_dir_reg && !eng_sel_reg[0])
        |=> (probe_tab_last == $past(probe_tab_last)))
        else $error("unselected table byte changed on a write");

    err_data_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (setup && !hit) |=> (PRDATA == 32'h0000_0000 && PSLVERR))
        else $error("refused access not answered with zero data and an error");

    err_resp_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        (setup && port_sel == 3'h0) |=> (PSLVERR && PREADY == PENABLE))
        else $error("access outside ports 1 to 7 not answered with an error");

    reset_clear_a: assert property (@(posedge SYS_CLK)
        $past(SYS_RST) |-> (probe_first == 8'h00 && probe_last == 8'h00 && probe_wr_done))
        else $error("staged bytes or status wrong after reset");

    if_done_gap_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
        start |-> ##DONE_GAP (state_reg == acl_stage_pkg::ENG_IDLE))
        else $error("engine still busy after the transfer should end");
endmodule

//--- inc/acl_stage_pkg.sv
// Constants for the per-port access-control entry staging registers.
// Assumes word-wide APB access, one register index per aligned 32-bit word.
package acl_stage_pkg;
    localparam int ADDR_W = 17;
    localparam int PORT_FIRST = 1;
    localparam int PORT_LAST = 7;
    localparam int STAGE_BYTES = 16;
    localparam int ENTRIES = 16;
    localparam int XFER_CYCLES = 4;

    // Register indexes within a port; byte address is four times the full index.
    localparam logic [11:0] OFF_FIRST_RULE = 12'h600;
    localparam logic [11:0] OFF_MODE = 12'h601;
    localparam logic [11:0] OFF_MAC5 = 12'h602;
    localparam logic [11:0] OFF_MAC4 = 12'h603;
    localparam logic [11:0] OFF_MAC3 = 12'h604;
    localparam logic [11:0] OFF_MAC2 = 12'h605;
    localparam logic [11:0] OFF_MAC1 = 12'h606;
    localparam logic [11:0] OFF_MAC0 = 12'h607;
    localparam logic [11:0] OFF_ETYPE_HI = 12'h608;
    localparam logic [11:0] OFF_ETYPE_LO = 12'h609;
    localparam logic [11:0] OFF_PRIO = 12'h60a;
    localparam logic [11:0] OFF_REMARK_MAP = 12'h60b;
    localparam logic [11:0] OFF_SPARE = 12'h60c;
    localparam logic [11:0] OFF_FWD_MAP = 12'h60d;
    localparam logic [11:0] OFF_RULESET_HI = 12'h60e;
    localparam logic [11:0] OFF_RULESET_LO = 12'h60f;
    localparam logic [11:0] OFF_SEL_HI = 12'h610;
    localparam logic [11:0] OFF_SEL_LO = 12'h611;
    localparam logic [11:0] OFF_CTRL = 12'h612;

    // Field positions.
    localparam int PRIO_MODE_LSB = 6;
    localparam int PRIO_LSB = 3;
    localparam int REMARK_EN_BIT = 2;
    localparam int REMARK_HI_LSB = 0;
    localparam int REMARK_LO_BIT = 7;
    localparam int MAP_MODE_LSB = 5;
    localparam int FWD_MAP_W = 7;
    localparam int CTRL_WR_DONE_BIT = 6;
    localparam int CTRL_RD_DONE_BIT = 5;
    localparam int CTRL_DIR_BIT = 4;
    localparam int CTRL_INDEX_W = 4;

    // Reset values and writable-bit masks.
    localparam logic [7:0] STAGE_RST = 8'h00;
    localparam logic [7:0] SEL_RST = 8'h00;
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic DONE_RST = 1'b1;
    localparam logic [7:0] FIRST_RULE_WMASK = 8'h0f;
    localparam logic [7:0] CTRL_WMASK = 8'h1f;

    typedef enum logic {ENG_IDLE, ENG_BUSY} engine_state_t;
endpackage

//--- sim/tb_acl_entry_staging_registers.sv
// Self-checking bench for the access-control entry staging registers.
// Assumes the design package is compiled first; the bench is the only APB master.
`timescale 1ns/1ps
module tb_acl_entry_staging_registers;
    localparam int XC = 8;
    localparam int TIMEOUT = 20000;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [16:0] paddr = 17'h00000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] rd_data;
    logic rd_err;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;

    always #50 sys_clk = ~sys_clk;

    acl_entry_staging_registers #(.XFER_CYCLES(XC)) u_acl_entry_staging_registers (
        .SYS_CLK(sys_clk),
        .SYS_RST(sys_rst),
        .PSEL(psel),
        .PENABLE(penable),
        .PWRITE(pwrite),
        .PADDR(paddr),
        .PWDATA(pwdata),
        .PRDATA(prdata),
        .PREADY(pready),
        .PSLVERR(pslverr)
    );

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
        begin
            $display("Testbench passed");
        end
        else
        begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [16:0] adr(input int p, input logic [11:0] off);
        return {p[2:0], off, 2'b00};
    endfunction

    function automatic logic [7:0] pat(input int i);
        return {i[3:0], ~i[3:0]};
    endfunction

    // Only the low nibble of the first staged byte is writable.
    function automatic logic [7:0] msk(input int i, input logic [7:0] d);
        return (i == 0) ? (d & 8'h0f) : d;
    endfunction

    // Setup cycle, then access until ready, at most 16 edges; results are taken at the last edge waited for.
    task automatic apb(input logic w, input logic [16:0] a, input logic [7:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            err_count++;
        end
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input int p, input logic [11:0] off, input logic [7:0] d);
        apb(1'b1, adr(p, off), d);
    endtask

    task automatic rd_chk(input int p, input logic [11:0] off, input logic [7:0] exp);
        apb(1'b0, adr(p, off), 8'h00);
        chk(rd_data, {24'h000000, exp});
        chk({31'h00000000, rd_err}, 32'h00000000);
    endtask

    // Starts a transfer, sees its status bit low while busy, then polls it back to one.
    task automatic xfer(input int p, input logic [7:0] ctl, input logic [15:0] sel, input int sb);
        logic [7:0] busy;
        int n;
        busy = {3'h3, ctl[4:0]};
        busy[sb] = 1'b0;
        wr(p, acl_stage_pkg::OFF_CTRL, ctl);
        wr(p, acl_stage_pkg::OFF_SEL_HI, sel[15:8]);
        wr(p, acl_stage_pkg::OFF_SEL_LO, sel[7:0]);
        rd_chk(p, acl_stage_pkg::OFF_CTRL, busy);
        n = 0;
        while (rd_data[sb] !== 1'b1 && n < 40)
        begin
            apb(1'b0, adr(p, acl_stage_pkg::OFF_CTRL), 8'h00);
            n++;
        end
        chk(rd_data, {24'h000000, 3'h3, ctl[4:0]});
    endtask

    // Selected bytes hold the table pattern (byte 8 may differ); the rest read zero.
    task automatic stage_chk(input int p, input logic [15:0] sel, input logic [7:0] b8);
        for (int i = 0; i < 16; i++)
        begin
            rd_chk(p, 12'h600 + i[11:0], sel[15-i] ? ((i == 8) ? b8 : msk(i, pat(i))) : 8'h00);
        end
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles >= TIMEOUT)
        begin
            err_count++;
            finish_test();
        end
    end

    initial
    begin
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int p = 1; p <= 7; p++)
        begin
            for (int i = 0; i < 18; i++)
            begin
                rd_chk(p, 12'h600 + i[11:0], 8'h00);
            end
            rd_chk(p, acl_stage_pkg::OFF_CTRL, 8'h60);
        end
        for (int k = 0; k < 2; k++)
        begin
            for (int i = 0; i < 16; i++)
            begin
                wr(3, 12'h600 + i[11:0], pat(i) ^ {8{k[0]}});
            end
            for (int i = 0; i < 16; i++)
            begin
                rd_chk(3, 12'h600 + i[11:0], msk(i, pat(i) ^ {8{k[0]}}));
            end
        end
        rd_chk(4, acl_stage_pkg::OFF_MAC5, 8'h00);
        wr(3, acl_stage_pkg::OFF_SEL_HI, 8'h5a);
        rd_chk(3, acl_stage_pkg::OFF_SEL_HI, 8'h5a);
        wr(3, acl_stage_pkg::OFF_CTRL, 8'hff);
        rd_chk(3, acl_stage_pkg::OFF_CTRL, 8'h7f);
        // A misaligned write must be refused and leave the register alone.
        apb(1'b1, adr(3, acl_stage_pkg::OFF_MAC5) | 17'h00001, 8'h11);
        chk({31'h00000000, rd_err}, 32'h00000001);
        rd_chk(3, acl_stage_pkg::OFF_MAC5, ~pat(2));
        wr(3, acl_stage_pkg::OFF_RULESET_HI, 8'h3c);
        rd_chk(3, acl_stage_pkg::OFF_RULESET_HI, 8'h3c);
        apb(1'b0, adr(0, acl_stage_pkg::OFF_MAC5), 8'h00);
        chk({rd_data[31:1], rd_err}, 32'h00000001);
        apb(1'b0, adr(1, 12'h613), 8'h00);
        chk({rd_data[31:1], rd_err}, 32'h00000001);
        for (int i = 0; i < 16; i++)
        begin
            wr(2, 12'h600 + i[11:0], pat(i));
        end
        xfer(2, 8'h15, 16'hffff, 6);
        for (int i = 0; i < 16; i++)
        begin
            wr(2, 12'h600 + i[11:0], 8'h00);
        end
        xfer(2, 8'h05, 16'h8141, 5);
        stage_chk(2, 16'h8141, pat(8));
        rd_chk(2, acl_stage_pkg::OFF_SEL_LO, 8'h41);
        // Only the first EtherType byte goes to the table; every other table byte must survive.
        wr(2, acl_stage_pkg::OFF_ETYPE_HI, 8'hc3);
        xfer(2, 8'h15, 16'h0080, 6);
        xfer(2, 8'h05, 16'hffff, 5);
        stage_chk(2, 16'hffff, 8'hc3);
        xfer(2, 8'h06, 16'hffff, 5);
        stage_chk(2, 16'h0000, 8'h00);
        // A start on port 2 while port 1 writes is refused but its select value is kept.
        wr(1, acl_stage_pkg::OFF_CTRL, 8'h10);
        wr(1, acl_stage_pkg::OFF_SEL_LO, 8'h01);
        wr(2, acl_stage_pkg::OFF_SEL_LO, 8'hff);
        rd_chk(2, acl_stage_pkg::OFF_CTRL, 8'h66);
        rd_chk(2, acl_stage_pkg::OFF_SEL_LO, 8'hff);
        rd_chk(1, acl_stage_pkg::OFF_CTRL, 8'h70);
        finish_test();
    end
endmodule
